/* File: can_rx_store.sv */
// Receive storage manager: queues, dedicated buffers and debug capture.
// Operation
// - Two independent queues, each up to 64 deep.
// - Watermark flag when fill level reaches watermark.
// - Put equals get after store: full, flag.
// - Host reads at start plus get times size.
// - Size code maps to 4..18 words.
// - Mode bit zero means blocking, reset default.
// - Blocking full queue takes no more elements.
// - Blocking full: drop, lost status, lost flag.
// - Overwrite full: replace oldest, advance both indices.
// - Host reads from get plus one when overwriting.
// - Acknowledge moves get; clears full unless put.
// - Plain buffer filter uses code 111, bits 00.
// - Up to 64 buffers; store, set buffer flag.
// - Last word sets new data, locks buffer.
// - Locked buffer filter element does not match.
// - Writing one clears only that new data flag.
// - Debug frames go to buffer index bits.
// - Role bits: 01 A, 10 B, 11 C.
// - After C, request DMA, reject debug frames.
// - DMA acknowledge drops request and re-arms capture.
// - Request only after A, B, C in order.
// - Debug stores set no flags; state readable.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module can_rx_store #(
  parameter int unsigned QUEUE_DEPTH = can_rx_store_pkg::MAX_DEPTH
) (
  // Clock, reset and freeze.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Frame announcement and words from the acceptance filter.
  input wire logic frm_start_i,
  input wire logic [1:0] frm_dest_i,
  input wire logic [5:0] frm_idx_i,
  input wire logic [1:0] frm_role_i,
  input wire logic word_valid_i,
  input wire logic [31:0] word_data_i,
  input wire logic word_last_i,
  // Message RAM write port.
  output logic ram_we_o,
  output logic [15:0] ram_addr_o,
  output logic [31:0] ram_wdata_o,
  // Buffer lock view for the filter, and DMA handshake.
  output logic [63:0] buffer_locked_o,
  output logic dma_req_o,
  input wire logic dma_ack_i,
  // Host side.
  can_rx_store_if.device host_if
);
  typedef struct packed {
    logic [1:0][5:0] put;
    logic [1:0][5:0] get;
    logic [1:0] full;
    logic [1:0] lost;
    logic [63:0] new_data;
    can_rx_store_pkg::dbg_state_type dbg;
    logic busy;
    logic drop;
    logic [1:0] dest;
    logic [5:0] idx;
    logic [1:0] role;
    logic [15:0] addr;
    logic ram_we;
    logic [15:0] ram_addr;
    logic [31:0] ram_wdata;
    logic [1:0] ev_wm;
    logic [1:0] ev_full;
    logic [1:0] ev_lost;
    logic ev_ded;
  } dev_state_type;

  dev_state_type s_q;
  dev_state_type s_d;

  function automatic logic [5:0] wrap_inc(input logic [5:0] p, input logic [6:0] depth);
    logic [6:0] n;
    n = {1'b0, p} + 7'h01;
    wrap_inc = (n >= depth) ? 6'h00 : n[5:0];
  endfunction

  function automatic logic [6:0] level(input logic [5:0] p, input logic [5:0] g,
                                       input logic f, input logic [6:0] depth);
    if (f) begin
      level = depth;
    end else if (p >= g) begin
      level = {1'b0, p} - {1'b0, g};
    end else begin
      level = {1'b0, p} + depth - {1'b0, g};
    end
  endfunction

  function automatic logic [15:0] slot_addr(input logic [15:0] base, input logic [5:0] i,
                                            input logic [2:0] code);
    logic [10:0] off;
    off = {5'h00, i} * {6'h00, can_rx_store_pkg::elem_words(code)};
    slot_addr = base + {5'h00, off};
  endfunction

  logic [1:0][6:0] depth_eff;
  logic [1:0][6:0] fill;
  always_comb begin
    for (int q = 0; q < 2; q++) begin
      depth_eff[q] = (host_if.cfg_depth[q] > 7'(QUEUE_DEPTH)) ? 7'(QUEUE_DEPTH) :
                     host_if.cfg_depth[q];
      fill[q] = level(s_q.put[q], s_q.get[q], s_q.full[q], depth_eff[q]);
    end
  end

  always_comb begin
    logic q;
    logic [6:0] f_new;
    q = 1'b0;
    f_new = 7'h00;
    s_d = s_q;
    s_d.ram_we = 1'b0;
    s_d.ev_wm = 2'h0;
    s_d.ev_full = 2'h0;
    s_d.ev_lost = 2'h0;
    s_d.ev_ded = 1'b0;
    for (int n = 0; n < 2; n++) begin
      s_d.lost[n] = s_q.lost[n] & ~host_if.lost_clr[n];
      if (host_if.ack_valid[n]) begin
        s_d.get[n] = host_if.ack_index[n];
        if (s_q.put[n] != host_if.ack_index[n]) begin
          s_d.full[n] = 1'b0;
        end
      end
    end
    s_d.new_data = s_q.new_data & ~host_if.nd_clr;
    if (s_q.dbg == can_rx_store_pkg::dbg_pending && dma_ack_i) begin
      s_d.dbg = can_rx_store_pkg::dbg_idle;
    end
    if (frm_start_i) begin
      s_d.busy = 1'b1;
      s_d.dest = frm_dest_i;
      s_d.idx = frm_idx_i;
      s_d.role = frm_role_i;
      s_d.drop = 1'b0;
      q = frm_dest_i[0];
      if (frm_dest_i == can_rx_store_pkg::DEST_BUFFER) begin
        s_d.addr = slot_addr(host_if.cfg_bstart, frm_idx_i, host_if.cfg_bsize);
        if (frm_role_i == can_rx_store_pkg::ROLE_DEDICATED) begin
          s_d.drop = s_q.new_data[frm_idx_i];
        end else if (s_q.dbg == can_rx_store_pkg::dbg_pending) begin
          s_d.drop = 1'b1;
        end else begin
          unique case (frm_role_i)
            can_rx_store_pkg::ROLE_B: s_d.drop = s_q.dbg != can_rx_store_pkg::dbg_got_a;
            can_rx_store_pkg::ROLE_C: s_d.drop = s_q.dbg != can_rx_store_pkg::dbg_got_ab;
            default: s_d.drop = 1'b0;
          endcase
          if (s_d.drop) begin
            s_d.dbg = can_rx_store_pkg::dbg_idle;
          end
        end
      end else if (frm_dest_i[1]) begin
        s_d.drop = 1'b1;
      end else begin
        s_d.addr = slot_addr(host_if.cfg_start[q], s_q.put[q], host_if.cfg_qsize[q]);
        if (depth_eff[q] == 7'h00) begin
          s_d.drop = 1'b1;
        end else if (s_q.full[q] && !host_if.cfg_ovr[q]) begin
          s_d.drop = 1'b1;
          s_d.lost[q] = 1'b1;
          s_d.ev_lost[q] = 1'b1;
        end
      end
    end else if (s_q.busy && word_valid_i) begin
      q = s_q.dest[0];
      if (!s_q.drop) begin
        s_d.ram_we = 1'b1;
        s_d.ram_addr = s_q.addr;
        s_d.ram_wdata = word_data_i;
        s_d.addr = s_q.addr + 16'h0001;
      end
      if (word_last_i) begin
        s_d.busy = 1'b0;
        if (!s_q.drop && s_q.dest == can_rx_store_pkg::DEST_BUFFER) begin
          if (s_q.role == can_rx_store_pkg::ROLE_DEDICATED) begin
            s_d.new_data[s_q.idx] = 1'b1;
            s_d.ev_ded = 1'b1;
          end else begin
            unique case (s_q.role)
              can_rx_store_pkg::ROLE_A: s_d.dbg = can_rx_store_pkg::dbg_got_a;
              can_rx_store_pkg::ROLE_B: s_d.dbg = can_rx_store_pkg::dbg_got_ab;
              default: s_d.dbg = can_rx_store_pkg::dbg_pending;
            endcase
          end
        end else if (!s_q.drop) begin
          if (s_q.full[q] && host_if.cfg_ovr[q]) begin
            s_d.get[q] = wrap_inc(s_q.get[q], depth_eff[q]);
          end
          s_d.put[q] = wrap_inc(s_q.put[q], depth_eff[q]);
          s_d.full[q] = s_d.put[q] == s_d.get[q];
          s_d.ev_full[q] = s_d.full[q];
          f_new = level(s_d.put[q], s_d.get[q], s_d.full[q], depth_eff[q]);
          s_d.ev_wm[q] = host_if.cfg_wmark[q] != 7'h00 &&
                         f_new == host_if.cfg_wmark[q];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.dbg <= can_rx_store_pkg::dbg_idle;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    unique case (s_q.dbg)
      can_rx_store_pkg::dbg_got_a: host_if.dbg_state = can_rx_store_pkg::DBG_CODE_A;
      can_rx_store_pkg::dbg_got_ab: host_if.dbg_state = can_rx_store_pkg::DBG_CODE_AB;
      can_rx_store_pkg::dbg_pending: host_if.dbg_state = can_rx_store_pkg::DBG_CODE_PENDING;
      default: host_if.dbg_state = can_rx_store_pkg::DBG_CODE_IDLE;
    endcase
  end

  // The filter skips locked buffers; the drop on start is only a backstop.
  assign buffer_locked_o = s_q.new_data;
  assign dma_req_o = s_q.dbg == can_rx_store_pkg::dbg_pending;
  assign ram_we_o = s_q.ram_we;
  assign ram_addr_o = s_q.ram_addr;
  assign ram_wdata_o = s_q.ram_wdata;
  assign host_if.st_get = s_q.get;
  assign host_if.st_put = s_q.put;
  assign host_if.st_fill = fill;
  assign host_if.st_full = s_q.full;
  assign host_if.st_lost = s_q.lost;
  assign host_if.ev_wm = s_q.ev_wm;
  assign host_if.ev_full = s_q.ev_full;
  assign host_if.ev_lost = s_q.ev_lost;
  assign host_if.ev_ded = s_q.ev_ded;
  assign host_if.new_data = s_q.new_data;
endmodule
`default_nettype wire

/* File: can_rx_store_chk.sv */
// Assertions on the link between the storage manager and its register block.
`timescale 1ns/1ps
`default_nettype none
module can_rx_store_chk (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link signals.
  input wire logic [1:0][6:0] cfg_wmark,
  input wire logic [1:0] cfg_ovr,
  input wire logic [1:0] ack_valid,
  input wire logic [1:0][5:0] ack_index,
  input wire logic [63:0] nd_clr,
  input wire logic [1:0][5:0] st_get,
  input wire logic [1:0][5:0] st_put,
  input wire logic [1:0][6:0] st_fill,
  input wire logic [1:0] st_full,
  input wire logic [1:0] st_lost,
  input wire logic [1:0] ev_wm,
  input wire logic [1:0] ev_full,
  input wire logic [1:0] ev_lost,
  input wire logic ev_ded,
  input wire logic [63:0] new_data,
  input wire logic [1:0] dbg_state
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  chk_full_index: assert property (ev_full[0] |-> st_full[0] && st_put[0] == st_get[0])
    else $error("Full event without equal indices.");
  chk_full_rise: assert property ($rose(st_full[0]) |-> ev_full[0])
    else $error("Full status rose without full event.");
  chk_wmark_level: assert property (ev_wm[0] |-> st_fill[0] == cfg_wmark[0])
    else $error("Watermark event at wrong level.");
  chk_lost_flag: assert property (ev_lost[0] |-> ##[0:1] st_lost[0])
    else $error("Lost event without lost status.");
  chk_block_hold: assert property (
    st_full[0] && !cfg_ovr[0] && !ack_valid[0] |=> st_put[0] == $past(st_put[0]))
    else $error("Blocking full queue advanced put.");
  chk_ack_get: assert property (
    ack_valid[0] && !cfg_ovr[0] |=> st_get[0] == $past(ack_index[0]))
    else $error("Acknowledge did not move get.");
  chk_ack_full: assert property (
    ack_valid[0] && st_put[0] != ack_index[0] |=> !st_full[0] || ev_full[0])
    else $error("Acknowledge left queue full.");
  chk_nd_keep: assert property (
    |nd_clr |=> (($past(new_data) & ~$past(nd_clr)) & ~new_data) == 64'h0)
    else $error("Clear touched an unwritten flag.");
  chk_dbg_order: assert property (
    dbg_state == 2'h3 && $past(dbg_state) != 2'h3 |-> $past(dbg_state) == 2'h2)
    else $error("Debug pending without A and B.");
  chk_dbg_silent: assert property (
    dbg_state != $past(dbg_state) && dbg_state != 2'h0 |->
      !ev_ded && (new_data & ~$past(new_data)) == 64'h0)
    else $error("Debug store raised a flag.");
  cover property (ev_full[0] && cfg_ovr[0]);
  cover property (ev_lost[0]);
  cover property (dbg_state == 2'h3);
endmodule
`default_nettype wire

/* File: can_rx_store_host.sv */
// Host-side register block reached over APB that drives the storage manager.
`timescale 1ns/1ps
`default_nettype none
module can_rx_store_host (
  // Clock, reset and freeze.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Storage manager side.
  can_rx_store_if.host dev_if
);
  typedef struct packed {
    logic [1:0][31:0] qcfg;
    logic [31:0] size;
    logic [6:0] irq;
    logic [31:0] rdata;
    logic slverr;
    logic [1:0] ack_valid;
    logic [1:0][5:0] ack_index;
    logic [1:0] lost_clr;
    logic [63:0] nd_clr;
  } host_state_type;

  host_state_type h_q;
  host_state_type h_d;
  logic [1:0][31:0] status;
  logic [1:0][15:0] read_addr;
  logic [6:0] irq_set;

  always_comb begin
    for (int n = 0; n < 2; n++) begin
      logic [5:0] g;
      logic [6:0] d;
      logic [10:0] off;
      d = dev_if.cfg_depth[n];
      g = dev_if.st_get[n];
      if (dev_if.st_full[n] && dev_if.cfg_ovr[n]) begin
        g = ({1'b0, g} + 7'h01 >= d) ? 6'h00 : g + 6'h01;
      end
      off = {5'h00, g} * {6'h00, can_rx_store_pkg::elem_words(dev_if.cfg_qsize[n])};
      read_addr[n] = dev_if.cfg_start[n] + {5'h00, off};
      status[n] = '0;
      status[n][5:0] = dev_if.st_get[n];
      status[n][can_rx_store_pkg::ST_PUT_POS +: 6] = dev_if.st_put[n];
      status[n][can_rx_store_pkg::ST_FILL_POS +: 7] = dev_if.st_fill[n];
      status[n][can_rx_store_pkg::ST_FULL_POS] = dev_if.st_full[n];
      status[n][can_rx_store_pkg::ST_LOST_POS] = dev_if.st_lost[n];
      irq_set[n * 3 +: 3] = {dev_if.ev_lost[n], dev_if.ev_full[n], dev_if.ev_wm[n]};
    end
    status[1][can_rx_store_pkg::ST_DBG_POS +: 2] = dev_if.dbg_state;
    irq_set[can_rx_store_pkg::IRQ_DED_POS] = dev_if.ev_ded;
  end

  always_comb begin
    logic wr;
    wr = psel_i && penable_i && pwrite_i;
    h_d = h_q;
    h_d.ack_valid = 2'h0;
    h_d.lost_clr = 2'h0;
    h_d.nd_clr = '0;
    h_d.irq = h_q.irq | irq_set;
    if (psel_i && !penable_i) begin
      h_d.slverr = 1'b0;
      h_d.rdata = '0;
      unique case (paddr_i)
        can_rx_store_pkg::REG_QUEUE0_CONFIG: h_d.rdata = h_q.qcfg[0];
        can_rx_store_pkg::REG_QUEUE1_CONFIG: h_d.rdata = h_q.qcfg[1];
        can_rx_store_pkg::REG_SIZE_CONFIG: h_d.rdata = h_q.size;
        can_rx_store_pkg::REG_QUEUE0_STATUS: h_d.rdata = status[0];
        can_rx_store_pkg::REG_QUEUE1_STATUS: h_d.rdata = status[1];
        can_rx_store_pkg::REG_QUEUE0_ACK: h_d.rdata = '0;
        can_rx_store_pkg::REG_QUEUE1_ACK: h_d.rdata = '0;
        can_rx_store_pkg::REG_NEW_DATA_LOW: h_d.rdata = dev_if.new_data[31:0];
        can_rx_store_pkg::REG_NEW_DATA_HIGH: h_d.rdata = dev_if.new_data[63:32];
        can_rx_store_pkg::REG_IRQ_FLAGS: h_d.rdata = {25'h0000000, h_q.irq};
        can_rx_store_pkg::REG_QUEUE0_READ_ADDR: h_d.rdata = {16'h0000, read_addr[0]};
        can_rx_store_pkg::REG_QUEUE1_READ_ADDR: h_d.rdata = {16'h0000, read_addr[1]};
        default: h_d.slverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr_i)
        can_rx_store_pkg::REG_QUEUE0_CONFIG: h_d.qcfg[0] = pwdata_i;
        can_rx_store_pkg::REG_QUEUE1_CONFIG: h_d.qcfg[1] = pwdata_i;
        can_rx_store_pkg::REG_SIZE_CONFIG: h_d.size = pwdata_i;
        can_rx_store_pkg::REG_QUEUE0_STATUS:
          h_d.lost_clr[0] = pwdata_i[can_rx_store_pkg::ST_LOST_POS];
        can_rx_store_pkg::REG_QUEUE1_STATUS:
          h_d.lost_clr[1] = pwdata_i[can_rx_store_pkg::ST_LOST_POS];
        can_rx_store_pkg::REG_QUEUE0_ACK: begin
          h_d.ack_valid[0] = 1'b1;
          h_d.ack_index[0] = pwdata_i[5:0];
        end
        can_rx_store_pkg::REG_QUEUE1_ACK: begin
          h_d.ack_valid[1] = 1'b1;
          h_d.ack_index[1] = pwdata_i[5:0];
        end
        can_rx_store_pkg::REG_NEW_DATA_LOW: h_d.nd_clr[31:0] = pwdata_i;
        can_rx_store_pkg::REG_NEW_DATA_HIGH: h_d.nd_clr[63:32] = pwdata_i;
        // A new event in the clearing cycle keeps its flag set.
        can_rx_store_pkg::REG_IRQ_FLAGS: h_d.irq = (h_q.irq & ~pwdata_i[6:0]) | irq_set;
        default: h_d.irq = h_q.irq | irq_set;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      h_q <= '0;
      h_q.qcfg <= {can_rx_store_pkg::CONFIG_RST, can_rx_store_pkg::CONFIG_RST};
      h_q.size <= can_rx_store_pkg::SIZE_RST;
    end else if (ce_i) begin
      h_q <= h_d;
    end
  end

  always_comb begin
    for (int n = 0; n < 2; n++) begin
      dev_if.cfg_start[n] = h_q.qcfg[n][15:0];
      dev_if.cfg_depth[n] = h_q.qcfg[n][can_rx_store_pkg::CFG_DEPTH_POS +: 7];
      dev_if.cfg_wmark[n] = h_q.qcfg[n][can_rx_store_pkg::CFG_WMARK_POS +: 7];
      dev_if.cfg_ovr[n] = h_q.qcfg[n][can_rx_store_pkg::CFG_OVR_POS];
    end
    dev_if.cfg_qsize[0] = h_q.size[2:0];
    dev_if.cfg_qsize[1] = h_q.size[can_rx_store_pkg::SIZE_Q1_POS +: 3];
    dev_if.cfg_bsize = h_q.size[can_rx_store_pkg::SIZE_BUF_POS +: 3];
    dev_if.cfg_bstart = h_q.size[can_rx_store_pkg::SIZE_BSTART_POS +: 16];
  end

  // Accesses never wait: the access phase always completes.
  assign pready_o = psel_i && penable_i;
  assign prdata_o = h_q.rdata;
  assign pslverr_o = psel_i && penable_i && h_q.slverr;
  assign dev_if.ack_valid = h_q.ack_valid;
  assign dev_if.ack_index = h_q.ack_index;
  assign dev_if.lost_clr = h_q.lost_clr;
  assign dev_if.nd_clr = h_q.nd_clr;
endmodule
`default_nettype wire

/* File: can_rx_store_if.sv */
// Connection between the storage manager and its host-side register block.
`timescale 1ns/1ps
`default_nettype none
interface can_rx_store_if;
  logic [1:0][15:0] cfg_start;
  logic [1:0][6:0] cfg_depth;
  logic [1:0][6:0] cfg_wmark;
  logic [1:0] cfg_ovr;
  logic [1:0][2:0] cfg_qsize;
  logic [2:0] cfg_bsize;
  logic [15:0] cfg_bstart;
  logic [1:0] ack_valid;
  logic [1:0][5:0] ack_index;
  logic [1:0] lost_clr;
  logic [63:0] nd_clr;
  logic [1:0][5:0] st_get;
  logic [1:0][5:0] st_put;
  logic [1:0][6:0] st_fill;
  logic [1:0] st_full;
  logic [1:0] st_lost;
  logic [1:0] ev_wm;
  logic [1:0] ev_full;
  logic [1:0] ev_lost;
  logic ev_ded;
  logic [63:0] new_data;
  logic [1:0] dbg_state;

  modport device (
    input cfg_start, cfg_depth, cfg_wmark, cfg_ovr, cfg_qsize, cfg_bsize,
    input cfg_bstart, ack_valid, ack_index, lost_clr, nd_clr,
    output st_get, st_put, st_fill, st_full, st_lost, ev_wm, ev_full,
    output ev_lost, ev_ded, new_data, dbg_state
  );
  modport host (
    output cfg_start, cfg_depth, cfg_wmark, cfg_ovr, cfg_qsize, cfg_bsize,
    output cfg_bstart, ack_valid, ack_index, lost_clr, nd_clr,
    input st_get, st_put, st_fill, st_full, st_lost, ev_wm, ev_full,
    input ev_lost, ev_ded, new_data, dbg_state
  );
endinterface
`default_nettype wire

/* File: can_rx_store_pkg.sv */
// Shared constants, types and helpers for the receive storage manager.
`default_nettype none
package can_rx_store_pkg;
  localparam int unsigned QUEUES = 2;
  localparam int unsigned MAX_DEPTH = 64;
  localparam int unsigned NUM_BUFFERS = 64;
  localparam int unsigned ADDR_W = 16;
  // Destination codes delivered by the acceptance filter with each frame.
  localparam logic [1:0] DEST_QUEUE0 = 2'h0;
  localparam logic [1:0] DEST_QUEUE1 = 2'h1;
  localparam logic [1:0] DEST_BUFFER = 2'h2;
  // Second filter ID bits [10:9]: plain buffer or debug message role.
  localparam logic [1:0] ROLE_DEDICATED = 2'h0;
  localparam logic [1:0] ROLE_A = 2'h1;
  localparam logic [1:0] ROLE_B = 2'h2;
  localparam logic [1:0] ROLE_C = 2'h3;
  // Readable debug sequence codes.
  localparam logic [1:0] DBG_CODE_IDLE = 2'h0;
  localparam logic [1:0] DBG_CODE_A = 2'h1;
  localparam logic [1:0] DBG_CODE_AB = 2'h2;
  localparam logic [1:0] DBG_CODE_PENDING = 2'h3;
  typedef enum logic [3:0] {
    dbg_idle = 4'h1,
    dbg_got_a = 4'h2,
    dbg_got_ab = 4'h4,
    dbg_pending = 4'h8
  } dbg_state_type;
  // Register byte offsets.
  localparam logic [7:0] REG_QUEUE0_CONFIG = 8'h00;
  localparam logic [7:0] REG_QUEUE1_CONFIG = 8'h04;
  localparam logic [7:0] REG_SIZE_CONFIG = 8'h08;
  localparam logic [7:0] REG_QUEUE0_STATUS = 8'h0C;
  localparam logic [7:0] REG_QUEUE1_STATUS = 8'h10;
  localparam logic [7:0] REG_QUEUE0_ACK = 8'h14;
  localparam logic [7:0] REG_QUEUE1_ACK = 8'h18;
  localparam logic [7:0] REG_NEW_DATA_LOW = 8'h1C;
  localparam logic [7:0] REG_NEW_DATA_HIGH = 8'h20;
  localparam logic [7:0] REG_IRQ_FLAGS = 8'h24;
  localparam logic [7:0] REG_QUEUE0_READ_ADDR = 8'h28;
  localparam logic [7:0] REG_QUEUE1_READ_ADDR = 8'h2C;
  // Queue config fields: start [15:0], depth [22:16], watermark [29:23].
  localparam int unsigned CFG_DEPTH_POS = 16;
  localparam int unsigned CFG_WMARK_POS = 23;
  localparam int unsigned CFG_OVR_POS = 31;
  // Size config fields: codes at [2:0], [6:4], [10:8]; buffer start [31:16].
  localparam int unsigned SIZE_Q1_POS = 4;
  localparam int unsigned SIZE_BUF_POS = 8;
  localparam int unsigned SIZE_BSTART_POS = 16;
  // Queue status fields.
  localparam int unsigned ST_PUT_POS = 8;
  localparam int unsigned ST_FILL_POS = 16;
  localparam int unsigned ST_FULL_POS = 24;
  localparam int unsigned ST_LOST_POS = 25;
  localparam int unsigned ST_DBG_POS = 30;
  // Interrupt flag bits: per queue watermark, full, lost; then buffer store.
  localparam int unsigned IRQ_Q1_POS = 3;
  localparam int unsigned IRQ_DED_POS = 6;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] SIZE_RST = 32'h0000_0000;
  localparam logic [6:0] DEPTH_MAX = 7'h40;

  function automatic logic [4:0] elem_words(input logic [2:0] code);
    unique case (code)
      3'h0: elem_words = 5'h04;
      3'h1: elem_words = 5'h05;
      3'h2: elem_words = 5'h06;
      3'h3: elem_words = 5'h07;
      3'h4: elem_words = 5'h08;
      3'h5: elem_words = 5'h0A;
      3'h6: elem_words = 5'h0E;
      3'h7: elem_words = 5'h12;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the storage manager and its register block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv, wd = 32'h0, ram_wdata;
  logic fs = 1'b0, wv = 1'b0, wl = 1'b0, ack = 1'b0, ram_we, dma_req, ce = 1'b1;
  logic [1:0] fd = 2'h0, fr = 2'h0;
  logic [5:0] fi = 6'h00;
  logic [15:0] ram_addr;
  logic [63:0] locked;
  logic [15:0] ra[$];
  logic [31:0] rd[$];
  int n_errors = 0, comparisons = 0, r1;
  can_rx_store_if bus ();
  can_rx_store i_can_rx_store (
    .clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .frm_start_i(fs), .frm_dest_i(fd),
    .frm_idx_i(fi), .frm_role_i(fr), .word_valid_i(wv), .word_data_i(wd), .word_last_i(wl),
    .ram_we_o(ram_we), .ram_addr_o(ram_addr), .ram_wdata_o(ram_wdata),
    .buffer_locked_o(locked), .dma_req_o(dma_req), .dma_ack_i(ack), .host_if(bus.device));
  can_rx_store_host i_can_rx_store_host (
    .clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .dev_if(bus.host));
  can_rx_store_chk i_can_rx_store_chk (
    .clk_sys_i(clk), .rst_i(rst), .cfg_wmark(bus.cfg_wmark), .cfg_ovr(bus.cfg_ovr),
    .ack_valid(bus.ack_valid), .ack_index(bus.ack_index), .nd_clr(bus.nd_clr),
    .st_get(bus.st_get), .st_put(bus.st_put), .st_fill(bus.st_fill), .st_full(bus.st_full),
    .st_lost(bus.st_lost), .ev_wm(bus.ev_wm), .ev_full(bus.ev_full), .ev_lost(bus.ev_lost),
    .ev_ded(bus.ev_ded), .new_data(bus.new_data), .dbg_state(bus.dbg_state));
  always #12.5 clk = ~clk;
  // Writes are taken on the falling edge, where the registered strobe has settled.
  always @(negedge clk) begin
    if (ram_we === 1'b1) begin
      ra.push_back(ram_addr);
      rd.push_back(ram_wdata);
    end
  end
  function automatic logic [31:0] st(input int g, input int p, input int f, input int fl,
      input int l);
    st = g | (p << 8) | (f << 16) | (fl << 24) | (l << 25);
  endfunction
  function automatic logic [31:0] words(input int c);
    int t[8] = '{4, 5, 6, 7, 8, 10, 14, 18};
    words = t[c];
  endfunction
  task automatic close_out();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) n_errors++;
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, rv & m);
  endtask
  task automatic send(input logic [1:0] d, input logic [5:0] ix, input logic [1:0] ro,
      input logic [15:0] base, input int n);
    logic [31:0] w[4];
    foreach (w[k]) w[k] = $urandom;
    ra.delete();
    rd.delete();
    @(posedge clk);
    fs <= 1'b1;
    fd <= d;
    fi <= ix;
    fr <= ro;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      fs <= 1'b0;
      wv <= 1'b1;
      wd <= w[k];
      wl <= (k == 3);
    end
    @(posedge clk);
    wv <= 1'b0;
    wl <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("ram writes", n, ra.size());
    for (int k = 0; k < n && k < ra.size(); k++) begin
      cmp("ram addr", base + k, ra[k]);
      cmp("ram data", w[k], rd[k]);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    void'($urandom(95));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk_rd("queue0 config", 8'h00, 32'hFFFFFFFF, 32'h0);
    chk_rd("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
    cmp("slave error", 32'h1, perr);
    done("reset");
    apb(1'b1, 8'h00, 32'h0104_0100);
    apb(1'b1, 8'h08, 32'h0200_0000);
    for (int k = 0; k < 4; k++) send(2'h0, 6'h00, 2'h0, 16'h0100 + 4 * k, 4);
    chk_rd("queue0 status", 8'h0C, 32'h03FF3F3F, st(0, 0, 4, 1, 0));
    chk_rd("flags", 8'h24, 32'h7F, 32'h03);
    send(2'h0, 6'h00, 2'h0, 16'h0, 0);
    chk_rd("queue0 status", 8'h0C, 32'h03FF3F3F, st(0, 0, 4, 1, 1));
    chk_rd("flags", 8'h24, 32'h7F, 32'h07);
    done("blocking");
    apb(1'b1, 8'h14, 32'h1);
    chk_rd("queue0 status", 8'h0C, 32'h03FF3F3F, st(1, 0, 3, 0, 1));
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h08, 32'h0200_0000 | c);
      chk_rd("read address", 8'h28, 32'hFFFF, 32'h0100 + words(c));
    end
    apb(1'b1, 8'h08, 32'h0200_0000);
    done("acknowledge");
    apb(1'b1, 8'h00, 32'h8104_0100);
    send(2'h0, 6'h00, 2'h0, 16'h0100, 4);
    send(2'h0, 6'h00, 2'h0, 16'h0104, 4);
    chk_rd("queue0 status", 8'h0C, 32'h03FF3F3F, st(2, 2, 4, 1, 1));
    chk_rd("read address", 8'h28, 32'hFFFF, 32'h010C);
    done("overwrite");
    apb(1'b1, 8'h04, 32'h0001_0180);
    send(2'h1, 6'h00, 2'h0, 16'h0180, 4);
    send(2'h3, 6'h00, 2'h0, 16'h0, 0);
    ce <= 1'b0;
    send(2'h1, 6'h00, 2'h0, 16'h0, 0);
    ce <= 1'b1;
    chk_rd("queue1 status", 8'h10, 32'h03FF3F3F, st(0, 0, 1, 1, 0));
    chk_rd("flags", 8'h24, 32'h38, 32'h10);
    done("queue1");
    r1 = $urandom_range(30, 0);
    send(2'h2, r1[5:0], 2'h0, 16'h0200 + 4 * r1, 4);
    send(2'h2, r1[5:0], 2'h0, 16'h0, 0);
    send(2'h2, 6'(r1 + 1), 2'h0, 16'h0200 + 4 * (r1 + 1), 4);
    cmp("locked", 32'h3 << r1, locked[31:0]);
    chk_rd("flags", 8'h24, 32'h40, 32'h40);
    apb(1'b1, 8'h1C, 32'h1 << r1);
    chk_rd("new data", 8'h1C, 32'hFFFFFFFF, 32'h2 << r1);
    done("buffer");
    for (int k = 0; k < 3; k++) begin
      send(2'h2, 6'(61 + k), 2'(k + 1), 16'h0200 + 4 * (61 + k), 4);
    end
    cmp("dma request", 32'h1, dma_req);
    chk_rd("debug state", 8'h10, 32'hC000_0000, 32'hC000_0000);
    chk_rd("new data high", 8'h20, 32'hE000_0000, 32'h0);
    send(2'h2, 6'd61, 2'h1, 16'h0, 0);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("dma request", 32'h0, dma_req);
    send(2'h2, 6'd61, 2'h1, 16'h0200 + 4 * 61, 4);
    send(2'h2, 6'd63, 2'h3, 16'h0, 0);
    chk_rd("debug state", 8'h10, 32'hC000_0000, 32'h0);
    cmp("dma request", 32'h0, dma_req);
    done("debug");
    close_out();
  end
endmodule
`default_nettype wire
